// File: hdl/lbc_pkg.sv
// Package for the local bus control block: shared constants and types.
// Assumes both ends run on one system clock with a synchronous reset.
//
// What this block does
// - Status state: select high memory/halt, low I/O/ack
// - Hold acknowledged: select floats, weakly keeps last level
// - Code/ack qualifier timed like select
// - Hold acknowledged: qualifier floats at last level
// - Lock low for prefix, swap, ack, descriptors
// - Hold acknowledged: lock floats with weak one
// - Cycle extends until ready low, then ends
// - Ready sampled on clock, ignored during hold
// - Float drivers first, then raise grant
// - Request drop lowers grant, resumes bus drive
// - Request asynchronous; grant always actively driven
// - Level request ignored while enable flag clear
// - Level interrupt: two ack cycles, 8-bit vector
// - Level request sampled each cycle, two early
// - Requester holds level request until ack begins
// - Non-maskable uses vector two, no ack cycles
// - Non-maskable edge: four low clocks, then first high clock
// - Operand request raised; ack low during transfer
// - Hold acknowledged: operand ack floats weak one
// - Stall input low halts wait/escape, interrupts allowed
// - Fault input low on wait/escape gives extension interrupt
// - Status state whenever a status line low
package lbc_pkg;

    // Cycle kinds requested by the processor core
    typedef enum logic [2:0]
    {
        LBC_CYC_MEM_RD  = 3'h0,
        LBC_CYC_MEM_WR  = 3'h1,
        LBC_CYC_CODE    = 3'h2,
        LBC_CYC_IO_RD   = 3'h3,
        LBC_CYC_IO_WR   = 3'h4,
        LBC_CYC_INTACK  = 3'h5,
        LBC_CYC_HALT    = 3'h6
    } lbc_cyc_t;

    // Bus sequencer states
    typedef enum logic [2:0]
    {
        LBC_ST_IDLE   = 3'h0,
        LBC_ST_STATUS = 3'h1,
        LBC_ST_CMD    = 3'h2,
        LBC_ST_FLOAT  = 3'h3,
        LBC_ST_HOLD   = 3'h4
    } lbc_state_t;

    localparam logic [7:0] LBC_NMI_VECTOR  = 8'h02;
    localparam logic [7:0] LBC_PEXT_VECTOR = 8'h10;
    localparam int         LBC_NMI_STABLE  = 4;
    localparam int         LBC_INTACK_CNT  = 2;
    localparam logic [1:0] LBC_ST_NONE     = 2'h3;

endpackage : lbc_pkg

// File: hdl/lbc_if.sv
// Interface joining the processor end and the system end of the local bus.
// Assumes the bench resolves tri-state pins from the enables.
`timescale 1ns/1ps
`default_nettype none
interface lbc_if;
    logic [1:0] cycle_status_n;
    logic       mem_io_sel;
    logic       mem_io_oe;
    logic       code_intack_qualifier;
    logic       code_intack_oe;
    logic       lock_n;
    logic       lock_oe;
    logic       ready_n;
    logic       hold_req;
    logic       bus_grant;
    logic       level_irq_request;
    logic       nmi_req;
    logic [7:0] vector_data;
    logic       coproc_operand_req;
    logic       coproc_operand_ack_n;
    logic       coproc_operand_ack_oe;
    logic       coproc_busy_n;
    logic       coproc_error_n;

    modport cpu
    (
        output cycle_status_n, mem_io_sel, mem_io_oe,
               code_intack_qualifier, code_intack_oe, lock_n, lock_oe,
               bus_grant, coproc_operand_ack_n, coproc_operand_ack_oe,
        input  ready_n, hold_req, level_irq_request, nmi_req, vector_data,
               coproc_operand_req, coproc_busy_n, coproc_error_n
    );
    modport sys
    (
        input  cycle_status_n, mem_io_sel, mem_io_oe,
               code_intack_qualifier, code_intack_oe, lock_n, lock_oe,
               bus_grant, coproc_operand_ack_n, coproc_operand_ack_oe,
        output ready_n, hold_req, level_irq_request, nmi_req, vector_data,
               coproc_operand_req, coproc_busy_n, coproc_error_n
    );
endinterface : lbc_if
`default_nettype wire

// File: hdl/lbc_cpu_end.sv
// Processor end of the local bus control: cycle sequencer, hold, interrupts.
// Assumes user-side requests come from core logic on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module lbc_cpu_end
    import lbc_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       srst_i,
    lbc_if.cpu              bus,
    input  wire logic       cyc_req_i,
    input  wire lbc_cyc_t   cyc_kind_i,
    input  wire logic       cyc_lock_i,
    input  wire logic       cyc_pext_i,
    output logic            cyc_busy_o,
    output logic            cyc_done_o,
    input  wire logic       int_enable_i,
    input  wire logic       instr_end_i,
    input  wire logic       wait_instr_i,
    output logic            irq_take_o,
    output logic [7:0]      irq_vector_o,
    output logic            stall_o,
    output logic            coproc_req_o
);

    ////////////////////////////////////////////////////////////////////
    // Synchronisers: first stage is read only by the second
    logic [5:0] s1_r;
    logic [5:0] s2_r;
    logic [5:0] async_in;
    assign async_in = {bus.hold_req, bus.level_irq_request, bus.nmi_req,
                       bus.coproc_operand_req, bus.coproc_busy_n,
                       bus.coproc_error_n};
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            s1_r <= 6'h03;
            s2_r <= 6'h03;
        end
        else
        begin
            s1_r <= async_in;
            s2_r <= s1_r;
        end
    end
    logic hold_s, irq_s, nmi_s, opreq_s, busy_s_n, err_s_n;
    assign {hold_s, irq_s, nmi_s, opreq_s, busy_s_n, err_s_n} = s2_r;

    ////////////////////////////////////////////////////////////////////
    // Bus sequencer
    lbc_state_t state_r;
    lbc_cyc_t   kind_r;
    logic       lock_r;
    logic       pext_r;
    logic       sel_r;
    logic       qual_r;
    logic [1:0] ack_cnt_r;
    logic       nmi_pend_r;
    logic       irq_pend_r;

    // Memory/IO and code/ack encoding for one cycle kind
    function automatic logic [1:0] qual_of(input lbc_cyc_t k);
        case (k)
            LBC_CYC_MEM_RD, LBC_CYC_MEM_WR, LBC_CYC_HALT: qual_of = 2'h2;
            LBC_CYC_CODE:   qual_of = 2'h3;
            LBC_CYC_INTACK: qual_of = 2'h0;
            default:        qual_of = 2'h1;
        endcase
    endfunction : qual_of

    // Status line encoding, not-status code outside the status state
    function automatic logic [1:0] status_of(input lbc_cyc_t k);
        case (k)
            LBC_CYC_INTACK, LBC_CYC_HALT:                 status_of = 2'h0;
            LBC_CYC_MEM_RD, LBC_CYC_CODE, LBC_CYC_IO_RD:  status_of = 2'h1;
            default:                                      status_of = 2'h2;
        endcase
    endfunction : status_of

    logic start_core;
    logic start_ack;
    assign start_ack  = irq_pend_r && (ack_cnt_r != 2'h0);
    assign start_core = cyc_req_i && !start_ack;

    // Hold has priority between unlocked cycles; grant follows the float state
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            state_r <= LBC_ST_IDLE;
            kind_r  <= LBC_CYC_MEM_RD;
            lock_r  <= 1'b0;
            pext_r  <= 1'b0;
        end
        else
        begin
            case (state_r)
                LBC_ST_IDLE:
                begin
                    if (hold_s && !lock_r)
                        state_r <= LBC_ST_FLOAT;
                    else if (start_ack || start_core)
                    begin
                        state_r <= LBC_ST_STATUS;
                        kind_r  <= start_ack ? LBC_CYC_INTACK : cyc_kind_i;
                        // A lock left standing from the last cycle covers
                        // this one too: lock spans current and next cycle
                        lock_r  <= start_ack || cyc_lock_i || lock_r;
                        pext_r  <= start_ack ? 1'b0 : cyc_pext_i;
                    end
                end
                LBC_ST_STATUS: state_r <= LBC_ST_CMD;
                LBC_ST_CMD:
                begin
                    if (!bus.ready_n)
                    begin
                        state_r <= LBC_ST_IDLE;
                        if (kind_r != LBC_CYC_INTACK || ack_cnt_r == 2'h1)
                            lock_r <= kind_r == LBC_CYC_INTACK
                                      ? 1'b0 : lock_r && cyc_lock_i;
                    end
                end
                LBC_ST_FLOAT: state_r <= LBC_ST_HOLD;
                LBC_ST_HOLD:
                    if (!hold_s)
                        state_r <= LBC_ST_IDLE;
                default: state_r <= LBC_ST_IDLE;
            endcase
        end
    end

    // Last driven select and qualifier levels, kept through hold
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            sel_r  <= 1'b0;
            qual_r <= 1'b0;
        end
        else if (state_r == LBC_ST_STATUS)
        begin
            {sel_r, qual_r} <= qual_of(kind_r);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupts
    logic nmi_d_r;
    logic [2:0] nmi_lo_r;
    logic nmi_rise;
    assign nmi_rise = nmi_s && !nmi_d_r && (nmi_lo_r >= 3'(LBC_NMI_STABLE));
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            nmi_d_r  <= 1'b0;
            nmi_lo_r <= 3'h0;
        end
        else
        begin
            nmi_d_r <= nmi_s;
            if (nmi_s)
                nmi_lo_r <= 3'h0;
            else if (nmi_lo_r < 3'(LBC_NMI_STABLE))
                nmi_lo_r <= nmi_lo_r + 3'h1;
        end
    end

    // Pending flags; a new edge wins over the clear of a served one
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            nmi_pend_r   <= 1'b0;
            irq_pend_r   <= 1'b0;
            ack_cnt_r    <= 2'h0;
            irq_take_o   <= 1'b0;
            irq_vector_o <= 8'h00;
        end
        else
        begin
            irq_take_o <= 1'b0;
            if (nmi_rise)
                nmi_pend_r <= 1'b1;
            if (instr_end_i && nmi_pend_r && !irq_pend_r)
            begin
                if (!nmi_rise)
                    nmi_pend_r <= 1'b0;
                irq_take_o   <= 1'b1;
                irq_vector_o <= LBC_NMI_VECTOR;
            end
            else if (instr_end_i && wait_instr_i && !err_s_n)
            begin
                irq_take_o   <= 1'b1;
                irq_vector_o <= LBC_PEXT_VECTOR;
            end
            else if (instr_end_i && irq_s && int_enable_i && !irq_pend_r)
            begin
                irq_pend_r <= 1'b1;
                ack_cnt_r  <= 2'(LBC_INTACK_CNT);
            end
            if (state_r == LBC_ST_CMD && !bus.ready_n
                && kind_r == LBC_CYC_INTACK)
            begin
                ack_cnt_r <= ack_cnt_r - 2'h1;
                if (ack_cnt_r == 2'h1)
                begin
                    irq_pend_r   <= 1'b0;
                    irq_take_o   <= 1'b1;
                    irq_vector_o <= bus.vector_data;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    logic       held;
    logic       in_cmd;
    logic [1:0] qual_now;
    assign qual_now = qual_of(kind_r);
    assign held   = state_r == LBC_ST_FLOAT || state_r == LBC_ST_HOLD;
    assign in_cmd = state_r == LBC_ST_CMD;
    assign bus.cycle_status_n = state_r == LBC_ST_STATUS
                                ? status_of(kind_r) : LBC_ST_NONE;
    assign bus.mem_io_sel     = state_r == LBC_ST_STATUS
                                ? qual_now[1] : sel_r;
    assign bus.code_intack_qualifier = state_r == LBC_ST_STATUS
                                ? qual_now[0] : qual_r;
    assign bus.mem_io_oe      = !held;
    assign bus.code_intack_oe = !held;
    assign bus.lock_n  = held ? 1'b1 : !lock_r;
    assign bus.lock_oe = !held;
    assign bus.bus_grant = state_r == LBC_ST_HOLD;
    assign bus.coproc_operand_ack_n = held ? 1'b1
                                      : !(pext_r && (in_cmd
                                      || state_r == LBC_ST_STATUS));
    assign bus.coproc_operand_ack_oe = !held;
    assign cyc_busy_o   = !held && state_r != LBC_ST_IDLE;
    assign cyc_done_o   = in_cmd && !bus.ready_n;
    assign stall_o      = wait_instr_i && !busy_s_n;
    assign coproc_req_o = opreq_s;

endmodule : lbc_cpu_end
`default_nettype wire

// File: hdl/lbc_sys_end.sv
// System end: bus controller ready, hold master, interrupt and coprocessor.
// Assumes user-side controls are on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module lbc_sys_end
    import lbc_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       srst_i,
    lbc_if.sys              bus,
    input  wire logic       ready_i,
    input  wire logic       hold_want_i,
    input  wire logic       irq_i,
    input  wire logic [7:0] vector_i,
    input  wire logic       nmi_i,
    input  wire logic       opreq_i,
    input  wire logic       busy_i,
    input  wire logic       error_i,
    output logic            granted_o,
    output logic            irq_acked_o
);

    logic irq_r;
    logic nmi_r;
    logic hold_r;
    logic grant_s1_r;
    logic grant_s2_r;
    logic intack_cyc;
    assign intack_cyc = bus.cycle_status_n == 2'h0 && !bus.mem_io_sel
                        && !bus.code_intack_qualifier;

    // Interrupt held until an acknowledge cycle begins
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            irq_r  <= 1'b0;
            nmi_r  <= 1'b0;
            hold_r <= 1'b0;
        end
        else
        begin
            if (intack_cyc)
                irq_r <= 1'b0;
            else if (irq_i)
                irq_r <= 1'b1;
            nmi_r  <= nmi_i;
            hold_r <= hold_want_i;
        end
    end

    // Grant is ours only after two flops of resync
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            grant_s1_r <= 1'b0;
            grant_s2_r <= 1'b0;
        end
        else
        begin
            grant_s1_r <= bus.bus_grant;
            grant_s2_r <= grant_s1_r;
        end
    end

    assign bus.ready_n            = !ready_i;
    assign bus.hold_req           = hold_r;
    assign bus.level_irq_request  = irq_r;
    assign bus.nmi_req            = nmi_r;
    assign bus.vector_data        = vector_i;
    assign bus.coproc_operand_req = opreq_i;
    assign bus.coproc_busy_n      = !busy_i;
    assign bus.coproc_error_n     = !error_i;
    assign granted_o   = grant_s2_r && hold_r;
    assign irq_acked_o = intack_cyc;

endmodule : lbc_sys_end
`default_nettype wire

// File: test/lbc_properties.sv
// Checker on the local bus interface signals.
// Assumes it sits beside lbc_if, clocked by the system clock.
`timescale 1ns/1ps
`default_nettype none
module lbc_properties
(
    input wire logic       clk_sys_i,
    input wire logic       srst_i,
    input wire logic [1:0] cycle_status_n,
    input wire logic       mem_io_sel,
    input wire logic       mem_io_oe,
    input wire logic       code_intack_qualifier,
    input wire logic       code_intack_oe,
    input wire logic       lock_n,
    input wire logic       lock_oe,
    input wire logic       ready_n,
    input wire logic       hold_req,
    input wire logic       bus_grant,
    input wire logic       coproc_operand_ack_n,
    input wire logic       coproc_operand_ack_oe
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    //////////////////////////////////////////////////////////////////////
    // Cycle phases seen on the wire
    sequence s_status;
        cycle_status_n != 2'h3;
    endsequence
    sequence s_intack;
        cycle_status_n == 2'h0 && !mem_io_sel;
    endsequence
    sequence s_no_ready;
        ready_n [*3];
    endsequence
    // Status lasts one cycle; ready high keeps the cycle open
    AST_STATUS_ONE:
        assert property (s_status |=> cycle_status_n == 2'h3)
        else $error("status longer than one cycle");
    AST_CYCLE_EXTENDS:
        assert property (s_status ##1 s_no_ready |-> cycle_status_n == 2'h3)
        else $error("new cycle before ready");
    AST_INTACK_LOCK:
        assert property (s_intack |-> !lock_n && !code_intack_qualifier)
        else $error("intack without lock or with code qualifier");
    // Hold: drivers off first, weak levels kept, no cycles
    AST_SEL_HOLD:
        assert property (bus_grant |-> !mem_io_oe && !code_intack_oe
            && $stable(mem_io_sel) && $stable(code_intack_qualifier))
        else $error("select or qualifier moved in hold");
    AST_WEAK_ONE:
        assert property (bus_grant |-> !lock_oe && lock_n
            && !coproc_operand_ack_oe && coproc_operand_ack_n)
        else $error("lock or operand ack not weak one in hold");
    AST_FLOAT_FIRST:
        assert property ($rose(bus_grant) |-> !$past(mem_io_oe)
            && !$past(lock_oe))
        else $error("grant before drivers floated");
    AST_GRANT_DROP:
        assert property (bus_grant && !hold_req |-> ##[1:6] !bus_grant)
        else $error("grant kept after request dropped");
    AST_HOLD_QUIET:
        assert property (bus_grant |-> cycle_status_n == 2'h3)
        else $error("bus cycle during hold");
endmodule : lbc_properties
`default_nettype wire

// File: test/cpu_local_bus_control_tb.sv
// Testbench: processor end and system end joined by lbc_if.
// Assumes package, interface and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module cpu_local_bus_control_tb
    import lbc_pkg::*;
;
    logic       clk_sys_i, srst_i, cyc_req_i, cyc_lock_i, cyc_pext_i;
    logic       int_enable_i, instr_end_i, wait_instr_i, ready_i;
    logic       hold_want_i, irq_i, nmi_i, opreq_i, busy_i, error_i;
    logic       cyc_busy_o, cyc_done_o, irq_take_o, stall_o, coproc_req_o;
    logic       granted_o, irq_acked_o;
    logic [7:0] vector_i, irq_vector_o;
    lbc_cyc_t   cyc_kind_i;
    int         error_cnt = 0, comparisons = 0, cycles = 0;
    lbc_if      bi();
    //////////////////////////////////////////////////////////////////////
    lbc_cpu_end u_lbc_cpu_end
    (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .bus(bi),
        .cyc_req_i(cyc_req_i), .cyc_kind_i(cyc_kind_i),
        .cyc_lock_i(cyc_lock_i), .cyc_pext_i(cyc_pext_i),
        .cyc_busy_o(cyc_busy_o), .cyc_done_o(cyc_done_o),
        .int_enable_i(int_enable_i), .instr_end_i(instr_end_i),
        .wait_instr_i(wait_instr_i), .irq_take_o(irq_take_o),
        .irq_vector_o(irq_vector_o), .stall_o(stall_o),
        .coproc_req_o(coproc_req_o)
    );
    lbc_sys_end u_lbc_sys_end
    (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .bus(bi),
        .ready_i(ready_i), .hold_want_i(hold_want_i), .irq_i(irq_i),
        .vector_i(vector_i), .nmi_i(nmi_i), .opreq_i(opreq_i),
        .busy_i(busy_i), .error_i(error_i), .granted_o(granted_o),
        .irq_acked_o(irq_acked_o)
    );
    lbc_properties u_props
    (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .cycle_status_n(bi.cycle_status_n), .mem_io_sel(bi.mem_io_sel),
        .mem_io_oe(bi.mem_io_oe), .lock_n(bi.lock_n), .lock_oe(bi.lock_oe),
        .code_intack_qualifier(bi.code_intack_qualifier),
        .code_intack_oe(bi.code_intack_oe), .ready_n(bi.ready_n),
        .hold_req(bi.hold_req), .bus_grant(bi.bus_grant),
        .coproc_operand_ack_n(bi.coproc_operand_ack_n),
        .coproc_operand_ack_oe(bi.coproc_operand_ack_oe)
    );
    // 40 MHz clock
    initial
    begin
        clk_sys_i = 1'h0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // Hang guard: whole run needs well under a thousand cycles
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            error_cnt++;
            print_verdict();
        end
    end
    //////////////////////////////////////////////////////////////////////
    task automatic nclk(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : nclk
    task automatic chk(input string nm, input logic [7:0] exp,
                       input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic print_verdict();
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    // Count intack cycles, catch a taken interrupt; requester lets go
    // only once the acknowledge has begun
    task automatic watch(input int n, output int a, output int t,
                         output logic [7:0] v);
        a = 0;
        t = 0;
        v = 8'h0;
        repeat (n)
        begin
            nclk(1);
            if (bi.cycle_status_n === 2'h0 && bi.mem_io_sel === 1'h0)
                a++;
            if (irq_acked_o === 1'h1)
                irq_i = 1'h0;
            if (irq_take_o === 1'h1)
            begin
                t++;
                v = irq_vector_o;
            end
        end
    endtask : watch
    // One cycle: ex is {status, select, qualifier}; dly stretches it
    task automatic run_cycle(input lbc_cyc_t k, input logic lk,
        input logic px, input logic [3:0] ex, input logic elk, input int dly);
        int i;
        cyc_kind_i = k;
        cyc_lock_i = lk;
        cyc_pext_i = px;
        cyc_req_i = 1'h1;
        nclk(1);
        cyc_req_i = 1'h0;
        chk("kind", 8'(ex), 8'({bi.cycle_status_n, bi.mem_io_sel,
            bi.code_intack_qualifier}));
        chk("lock", 8'(elk), 8'(bi.lock_n));
        chk("opack", 8'(!px), 8'(bi.coproc_operand_ack_n));
        chk("drive", 8'h1, 8'(bi.mem_io_oe));
        chk("busy", 8'h1, 8'(cyc_busy_o));
        nclk(dly);
        chk("early", 8'h0, 8'(cyc_done_o));
        ready_i = 1'h1;
        #1;
        for (i = 0; i < 6 && cyc_done_o !== 1'h1; i++)
            nclk(1);
        chk("done", 8'h1, 8'(cyc_done_o));
        nclk(1);
        ready_i = 1'h0;
    endtask : run_cycle
    //////////////////////////////////////////////////////////////////////
    task automatic test_cycles();
        lbc_cyc_t   k[6] = '{LBC_CYC_MEM_RD, LBC_CYC_MEM_WR, LBC_CYC_CODE,
                             LBC_CYC_IO_RD, LBC_CYC_IO_WR, LBC_CYC_HALT};
        logic [3:0] e[6] = '{4'h6, 4'ha, 4'h7, 4'h5, 4'h9, 4'h2};
        for (int i = 0; i < 6; i++)
            run_cycle(k[i], 1'h0, 1'h0, e[i], 1'h1, i);
        run_cycle(LBC_CYC_MEM_WR, 1'h1, 1'h0, 4'ha, 1'h0, 1);
        run_cycle(LBC_CYC_MEM_RD, 1'h0, 1'h0, 4'h6, 1'h0, 0);
        run_cycle(LBC_CYC_MEM_RD, 1'h0, 1'h1, 4'h6, 1'h1, 2);
    endtask : test_cycles
    // Hold: ready pulses in hold must not end anything
    task automatic test_hold();
        int i;
        hold_want_i = 1'h1;
        for (i = 0; i < 10 && bi.bus_grant !== 1'h1; i++)
            nclk(1);
        ready_i = 1'h1;
        nclk(4);
        chk("grant", 8'h3, 8'({bi.bus_grant, granted_o}));
        chk("hold_rdy", 8'h0, 8'(cyc_done_o));
        ready_i = 1'h0;
        hold_want_i = 1'h0;
        for (i = 0; i < 10 && bi.bus_grant !== 1'h0; i++)
            nclk(1);
        chk("release", 8'h0, 8'(bi.bus_grant));
        run_cycle(LBC_CYC_IO_RD, 1'h0, 1'h0, 4'h5, 1'h1, 1);
    endtask : test_hold
    // Level request masked, then two acknowledges with vector
    task automatic test_irq();
        int a, t;
        logic [7:0] v;
        vector_i = 8'h5a;
        irq_i = 1'h1;
        instr_end_i = 1'h1;
        watch(12, a, t, v);
        chk("masked", 8'h0, 8'(a + t));
        int_enable_i = 1'h1;
        ready_i = 1'h1;
        watch(30, a, t, v);
        chk("acks", 8'h2, 8'(a));
        chk("irq_vec", 8'h5a, v);
        {ready_i, int_enable_i, irq_i, instr_end_i} = 4'h0;
    endtask : test_irq
    // Non-maskable: vector two, no acks; a two-cycle low is too short
    task automatic test_nmi();
        int a, t;
        logic [7:0] v;
        nmi_i = 1'h1;
        instr_end_i = 1'h1;
        watch(20, a, t, v);
        chk("nmi_acks", 8'h0, 8'(a));
        chk("nmi_vec", LBC_NMI_VECTOR, v);
        nmi_i = 1'h0;
        nclk(2);
        nmi_i = 1'h1;
        watch(12, a, t, v);
        chk("nmi_short", 8'h0, 8'(t));
        {nmi_i, instr_end_i} = 2'h0;
    endtask : test_nmi
    // Operand request, stall and fault from the coprocessor
    task automatic test_copro();
        int a, t;
        logic [7:0] v;
        opreq_i = 1'h1;
        nclk(1);
        chk("opreq_sync", 8'h0, 8'(coproc_req_o));
        nclk(5);
        chk("opreq", 8'h1, 8'(coproc_req_o));
        opreq_i = 1'h0;
        {wait_instr_i, busy_i} = 2'h3;
        nclk(6);
        chk("stall", 8'h1, 8'(stall_o));
        busy_i = 1'h0;
        nclk(6);
        chk("unstall", 8'h0, 8'(stall_o));
        {error_i, instr_end_i} = 2'h3;
        watch(16, a, t, v);
        chk("pext_vec", LBC_PEXT_VECTOR, v);
        {error_i, instr_end_i, wait_instr_i} = 3'h0;
    endtask : test_copro
    //////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {cyc_req_i, cyc_lock_i, cyc_pext_i, int_enable_i, instr_end_i,
         wait_instr_i, ready_i, hold_want_i, irq_i, nmi_i, opreq_i,
         busy_i, error_i} = 13'h0;
        srst_i = 1'h1;
        vector_i = 8'h0;
        cyc_kind_i = LBC_CYC_MEM_RD;
        nclk(6);
        srst_i = 1'h0;
        test_cycles();
        test_hold();
        test_irq();
        test_nmi();
        test_copro();
        print_verdict();
    end
endmodule : cpu_local_bus_control_tb
`default_nettype wire
